// File: verilog/serdes_lane_status_config.v
/*
 * Lane configuration and lane error status for one switch port, with an AXI4-Lite slave,
 * a sticky event interrupt and synchronisers for every lane-side input.
 * Assumes lane event inputs are level pulses from the serial-lane clock domain lasting at least
 * three aclk periods, and that the lane clock is sampled as data only.
 */
`timescale 1ns/100ps
`include "lane_status_consts.vh"

module serdes_lane_status_config
(
    // Clock and reset.
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        fund_resetn,
    // Write address channel.
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // Write data channel.
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // Write response channel.
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // Read address channel.
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // Read data channel.
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Port mode straps and link state.
    input  wire        port_is_odd,
    input  wire        merged_mode,
    input  wire        serdes_test_mode,
    input  wire [3:0]  ltssm_state,
    // Lane side inputs.
    input  wire        lane_clk,
    input  wire [7:0]  receiver_detected_raw,
    input  wire [7:0]  disparity_error_evt,
    input  wire [7:0]  decode_error_evt,
    input  wire [7:0]  underflow_evt,
    input  wire [7:0]  overflow_evt,
    // Lane controls and interrupt.
    output reg  [7:0]  receiver_detected,
    output reg         transmit_swing_select,
    output reg         lane_clk_rise,
    output reg         irq
);

////////////////////////////////////////////////////////////////////////////////////////////////////

    localparam NIN = 5 * `LANES + `LTSSM_W + 4;

    function [7:0] w1c;
        input [7:0] cur;
        input [7:0] set;
        input [7:0] clr;
        input       en;
        begin
            w1c = (cur & ~(clr & {8{en}})) | set;
        end
    endfunction

    // Returns one for an address that names a register of this block.
    function addr_mapped;
        input [11:0] addr;
        begin
            if (addr == `OFF_SERDES_CFG)
            begin
                addr_mapped = 1'b1;
            end
            else if (addr == `OFF_CODING_STS)
            begin
                addr_mapped = 1'b1;
            end
            else if (addr == `OFF_ELASTIC_STS)
            begin
                addr_mapped = 1'b1;
            end
            else if (addr == `OFF_IRQ_STATUS)
            begin
                addr_mapped = 1'b1;
            end
            else if (addr == `OFF_IRQ_MASK)
            begin
                addr_mapped = 1'b1;
            end
            else
            begin
                addr_mapped = 1'b0;
            end
        end
    endfunction

    wire [NIN-1:0] async_in = {lane_clk, port_is_odd, merged_mode, serdes_test_mode, ltssm_state,
                               receiver_detected_raw, disparity_error_evt, decode_error_evt,
                               underflow_evt, overflow_evt};
    reg  [NIN-1:0] sync1_ff;
    reg  [NIN-1:0] sync2_ff;

    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi = gi + 1)
        begin : g_sync
            always @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    sync1_ff[gi] <= 1'b0;
                    sync2_ff[gi] <= 1'b0;
                end
                else
                begin
                    sync1_ff[gi] <= async_in[gi];
                    sync2_ff[gi] <= sync1_ff[gi];
                end
            end
        end
    endgenerate

    wire       s_lclk   = sync2_ff[NIN-1];
    wire       s_odd    = sync2_ff[NIN-2];
    wire       s_merged = sync2_ff[NIN-3];
    wire       s_test   = sync2_ff[NIN-4];
    wire [3:0] s_ltssm  = sync2_ff[NIN-5 -: 4];
    wire [7:0] s_rdet   = sync2_ff[39:32];
    wire [7:0] s_pde    = sync2_ff[31:24];
    wire [7:0] s_dec    = sync2_ff[23:16];
    wire [7:0] s_und    = sync2_ff[15:8];
    wire [7:0] s_ovr    = sync2_ff[7:0];

////////////////////////////////////////////////////////////////////////////////////////////////////

    reg  [7:0] receiver_detect_force_ff;
    reg        swing_ff;
    reg  [7:0] disparity_error_flags_ff;
    reg  [7:0] decode_error_flags_ff;
    reg  [7:0] receive_underflow_flags_ff;
    reg  [7:0] receive_overflow_flags_ff;
    reg  [3:0] irq_status_ff;
    reg  [3:0] irq_mask_ff;
    reg        lclk_prev_ff;

    wire [7:0] lane_valid = (s_odd || !s_merged) ? ~`UPPER_LANE_MASK : `FULL_LANE_MASK;
    wire       st_l0      = (s_ltssm == `LTSSM_L0);
    wire       st_dec     = st_l0 || (s_ltssm == `LTSSM_CONFIG) || (s_ltssm == `LTSSM_DISABLED) ||
                            (s_ltssm == `LTSSM_HOT_RESET);
    wire [7:0] set_pde    = s_pde & lane_valid & {8{st_l0}};
    wire [7:0] set_dec    = s_dec & lane_valid & {8{st_dec}};
    wire [7:0] set_und    = s_und & lane_valid & {8{st_l0}};
    wire [7:0] set_ovr    = s_ovr & lane_valid & {8{st_l0}};
    wire [3:0] irq_evt    = {|set_ovr, |set_und, |set_dec, |set_pde};

    reg  [11:0] awaddr_ff;
    reg         aw_full_ff;
    reg  [31:0] wdata_ff;
    reg  [3:0]  wstrb_ff;
    reg         w_full_ff;
    wire        do_write = aw_full_ff && w_full_ff && !s_axi_bvalid;
    wire        wr_cfg   = do_write && (awaddr_ff == `OFF_SERDES_CFG);
    wire        wr_cod   = do_write && (awaddr_ff == `OFF_CODING_STS);
    wire        wr_ela   = do_write && (awaddr_ff == `OFF_ELASTIC_STS);
    wire        wr_msk   = do_write && (awaddr_ff == `OFF_IRQ_MASK);
    wire        rd_take  = s_axi_arvalid && s_axi_arready;
    wire        rd_irq   = rd_take && (s_axi_araddr == `OFF_IRQ_STATUS);

////////////////////////////////////////////////////////////////////////////////////////////////////

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            receiver_detect_force_ff <= 8'h00;
            swing_ff                 <= 1'b0;
            disparity_error_flags_ff <= 8'h00;
            decode_error_flags_ff    <= 8'h00;
            irq_status_ff            <= 4'h0;
            irq_mask_ff              <= 4'h0;
            lclk_prev_ff             <= 1'b0;
            receiver_detected        <= 8'h00;
            transmit_swing_select    <= 1'b0;
            lane_clk_rise            <= 1'b0;
            irq                      <= 1'b0;
        end
        else
        begin
            if (wr_cfg && wstrb_ff[0])
            begin
                receiver_detect_force_ff <= wdata_ff[`LO_FIELD_LSB +: 8];
            end
            if (wr_cfg && wstrb_ff[2])
            begin
                swing_ff <= wdata_ff[`SWING_BIT];
            end
            if (wr_msk && wstrb_ff[0])
            begin
                irq_mask_ff <= wdata_ff[3:0];
            end
            disparity_error_flags_ff <= w1c(disparity_error_flags_ff, set_pde,
                                            wdata_ff[`LO_FIELD_LSB +: 8], wr_cod && wstrb_ff[0]);
            decode_error_flags_ff    <= w1c(decode_error_flags_ff, set_dec,
                                            wdata_ff[`HI_FIELD_LSB +: 8], wr_cod && wstrb_ff[2]);
            irq_status_ff <= (rd_irq ? 4'h0 : irq_status_ff) | irq_evt;
            lclk_prev_ff  <= s_lclk;
            lane_clk_rise <= s_lclk && !lclk_prev_ff;
            receiver_detected <= (s_rdet | (s_test ? 8'h00 : receiver_detect_force_ff)) & lane_valid;
            transmit_swing_select <= swing_ff;
            irq <= |(((rd_irq ? 4'h0 : irq_status_ff) | irq_evt) & irq_mask_ff);
        end
    end

    // Elastic buffer flags are reset only by the fundamental reset.
    always @(posedge aclk)
    begin
        if (!fund_resetn)
        begin
            receive_underflow_flags_ff <= 8'h00;
            receive_overflow_flags_ff  <= 8'h00;
        end
        else if (aresetn)
        begin
            receive_underflow_flags_ff <= w1c(receive_underflow_flags_ff, set_und,
                                              wdata_ff[`LO_FIELD_LSB +: 8], wr_ela && wstrb_ff[0]);
            receive_overflow_flags_ff  <= w1c(receive_overflow_flags_ff, set_ovr,
                                              wdata_ff[`HI_FIELD_LSB +: 8], wr_ela && wstrb_ff[2]);
        end
    end

////////////////////////////////////////////////////////////////////////////////////////////////////

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awaddr_ff     <= 12'h000;
            aw_full_ff    <= 1'b0;
            wdata_ff      <= `ZERO32;
            wstrb_ff      <= 4'h0;
            w_full_ff     <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awaddr_ff     <= s_axi_awaddr;
                aw_full_ff    <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wdata_ff     <= s_axi_wdata;
                wstrb_ff     <= s_axi_wstrb;
                w_full_ff    <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                if (addr_mapped(awaddr_ff))
                begin
                    s_axi_bresp <= `RESP_OKAY;
                end
                else
                begin
                    s_axi_bresp <= `RESP_SLVERR;
                end
                aw_full_ff <= 1'b0;
                w_full_ff  <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= `ZERO32;
            s_axi_rresp   <= `RESP_OKAY;
        end
        else
        begin
            if (rd_take)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                if (addr_mapped(s_axi_araddr))
                begin
                    s_axi_rresp <= `RESP_OKAY;
                end
                else
                begin
                    s_axi_rresp <= `RESP_SLVERR;
                end
                if (s_axi_araddr == `OFF_SERDES_CFG)
                begin
                    s_axi_rdata <= {15'h0000, swing_ff, 8'h00, receiver_detect_force_ff};
                end
                else if (s_axi_araddr == `OFF_CODING_STS)
                begin
                    s_axi_rdata <= {8'h00, decode_error_flags_ff, 8'h00, disparity_error_flags_ff};
                end
                else if (s_axi_araddr == `OFF_ELASTIC_STS)
                begin
                    s_axi_rdata <= {8'h00, receive_overflow_flags_ff, 8'h00, receive_underflow_flags_ff};
                end
                else if (s_axi_araddr == `OFF_IRQ_STATUS)
                begin
                    s_axi_rdata <= {28'h0000000, irq_status_ff};
                end
                else if (s_axi_araddr == `OFF_IRQ_MASK)
                begin
                    s_axi_rdata <= {28'h0000000, irq_mask_ff};
                end
                else
                begin
                    s_axi_rdata <= `ZERO32;
                end
            end
            if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule // serdes_lane_status_config

// File: pkg/lane_status_consts.vh
/*
 * Constants for the lane configuration and status block: register offsets, field positions,
 * reset values, link training state codes and interrupt layout.
 * Assumes inclusion by bare name from the design file of the block.
 */
`ifndef LANE_STATUS_CONSTS_VH
`define LANE_STATUS_CONSTS_VH

`define LANES              8
`define ADDR_W             12
`define OFF_SERDES_CFG     12'h510
`define OFF_CODING_STS     12'h51C
`define OFF_ELASTIC_STS    12'h520
`define OFF_IRQ_STATUS     12'h530
`define OFF_IRQ_MASK       12'h534
`define LO_FIELD_LSB       0
`define HI_FIELD_LSB       16
`define SWING_BIT          16
`define UPPER_LANE_MASK    8'hF0
`define FULL_LANE_MASK     8'hFF
`define LTSSM_W            4
`define LTSSM_L0           4'h3
`define LTSSM_CONFIG       4'h2
`define LTSSM_DISABLED     4'hA
`define LTSSM_HOT_RESET    4'hB
`define IRQ_W              4
`define IRQ_DISPARITY      0
`define IRQ_DECODE         1
`define IRQ_UNDERFLOW      2
`define IRQ_OVERFLOW       3
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2
`define ZERO32             32'h00000000

`endif

// File: tb/serdes_lane_status_config_checker.sv
/* Assertion checker for the lane status block: bus timing, lane controls and the lane clock pulse.
   Assumes it is bound to the block's top module and sees only that module's ports. */
`timescale 1ns/100ps
module serdes_lane_status_config_checker
(
    // Clock and reset.
    input wire        aclk, aresetn,
    // Register bus.
    input wire        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready,
    input wire [1:0]  s_axi_bresp, s_axi_rresp,
    input wire        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
    input wire [11:0] s_axi_araddr,
    input wire [31:0] s_axi_rdata,
    // Lane side.
    input wire        port_is_odd, serdes_test_mode, transmit_swing_select, lane_clk_rise, irq,
    input wire [7:0]  receiver_detected_raw, receiver_detected
);
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
////////////////////////////////////////////////////////////////////////////////
property p_aw_block; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
a_aw_block: assert property (p_aw_block) else $error("awready high after take");
property p_b_lat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
a_b_lat: assert property (p_b_lat) else $error("write response late");
property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
a_b_hold: assert property (p_b_hold) else $error("write response dropped");
property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
a_r_lat: assert property (p_r_lat) else $error("read data late");
property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
a_r_hold: assert property (p_r_hold) else $error("read data dropped");
property p_unmapped; s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h600 |=>
    s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0; endproperty
a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
property p_odd; port_is_odd [*6] |-> receiver_detected[7:4] == 4'h0; endproperty
a_odd: assert property (p_odd) else $error("upper lanes active on odd port");
property p_test; (serdes_test_mode && receiver_detected_raw == 8'h00) [*6] |-> receiver_detected == 8'h00; endproperty
a_test: assert property (p_test) else $error("force used in test mode");
property p_swing; $changed(transmit_swing_select) |-> !s_axi_wready || $past(!s_axi_wready); endproperty
a_swing: assert property (p_swing) else $error("swing changed without write");
property p_rise; lane_clk_rise |=> !lane_clk_rise; endproperty
a_rise: assert property (p_rise) else $error("lane clock pulse too long");
c_irq: cover property (irq);
c_rise: cover property (lane_clk_rise);
c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // serdes_lane_status_config_checker

// File: tb/lane_partner.sv
/* Lane partner model: lane clock during bursts, per-lane event bursts and detection levels.
   Assumes the bench raises fire_go for one cycle per burst and holds kinds and lanes meanwhile. */
`timescale 1ns/100ps
module lane_partner
(
    input wire        aclk, fire_go,
    input wire [3:0]  kinds,
    input wire [7:0]  lanes, present,
    output reg        lane_clk,
    output wire [7:0] receiver_detected_raw, disparity_error_evt, decode_error_evt, underflow_evt, overflow_evt
);
reg [4:0] cnt;
initial lane_clk = 1'b0;
initial cnt = 5'h00;
// A burst holds the chosen events for twenty cycles; the lane clock runs only then.
always @(posedge aclk) cnt <= fire_go ? 5'h14 : (cnt != 5'h00 ? cnt - 5'h01 : 5'h00);
// Outside a burst the clock finishes its last half period and then rests low.
always #80 if (cnt != 5'h00 || lane_clk) lane_clk = ~lane_clk;
assign receiver_detected_raw = present;
assign disparity_error_evt = (cnt != 5'h00 && kinds[0]) ? lanes : 8'h00;
assign decode_error_evt = (cnt != 5'h00 && kinds[1]) ? lanes : 8'h00;
assign underflow_evt = (cnt != 5'h00 && kinds[2]) ? lanes : 8'h00;
assign overflow_evt = (cnt != 5'h00 && kinds[3]) ? lanes : 8'h00;
endmodule // lane_partner

// File: tb/serdes_lane_status_config_tb.sv
/* Self-checking bench for the lane status block with a register bus master and scenario tasks.
   Assumes the block, the lane partner and the checker are compiled first. */
`timescale 1ns/100ps
module serdes_lane_status_config_tb;
logic        aclk = 0, aresetn = 0, fund_resetn = 0, fire_go = 0;
logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
logic [31:0] s_axi_wdata = 0, rdat;
logic [3:0]  s_axi_wstrb = 4'hF, kinds = 0, ltssm_state = 4'h3;
logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
logic        port_is_odd = 0, merged_mode = 1, serdes_test_mode = 0;
logic [7:0]  lanes = 0, present = 0;
logic [1:0]  resp;
wire  [1:0]  s_axi_bresp, s_axi_rresp;
wire  [31:0] s_axi_rdata;
wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
wire         lane_clk, lane_clk_rise, irq, transmit_swing_select;
wire  [7:0]  receiver_detected_raw, receiver_detected, disparity_error_evt, decode_error_evt, underflow_evt, overflow_evt;
int          n_fail = 0, n_compared = 0;
int          n_lclk = 0, n_lrise = 0;
lane_partner lane_partner_inst (.aclk, .fire_go, .kinds, .lanes, .present, .lane_clk, .receiver_detected_raw,
    .disparity_error_evt, .decode_error_evt, .underflow_evt, .overflow_evt);
serdes_lane_status_config serdes_lane_status_config_inst (.aclk, .aresetn, .fund_resetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .port_is_odd, .merged_mode, .serdes_test_mode, .ltssm_state, .lane_clk, .receiver_detected_raw, .disparity_error_evt,
    .decode_error_evt, .underflow_evt, .overflow_evt, .receiver_detected, .transmit_swing_select, .lane_clk_rise, .irq);
always #5 aclk = ~aclk;
always @(posedge lane_clk) n_lclk++;
always @(posedge aclk) if (lane_clk_rise) n_lrise++;
////////////////////////////////////////////////////////////////////////////////
task automatic chk(input [31:0] seen, input [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
        n_fail++;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
endtask
task automatic close_out;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
        $display("TB: PASS");
    else
        $display("TB: FAIL");
    $finish;
endtask
task automatic wr(input [11:0] a, input [31:0] d, input [3:0] s = 4'hF);
    logic aw, w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w))
    begin
        @(posedge aclk);
        if (s_axi_awready && !aw) begin aw = 1; s_axi_awvalid <= 1'b0; end
        if (s_axi_wready && !w) begin w = 1; s_axi_wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
endtask
task automatic rc(input [11:0] a, input [31:0] exp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
    chk(rdat, exp);
endtask
task automatic fire(input [3:0] k, input [7:0] l);
    kinds <= k;
    lanes <= l;
    fire_go <= 1'b1;
    @(posedge aclk);
    fire_go <= 1'b0;
    repeat (30) @(posedge aclk);
endtask
////////////////////////////////////////////////////////////////////////////////
task automatic t_reset;
    wr(12'h600, 32'hFFFFFFFF);
    chk(resp, 2'h2);
    rc(12'h600, 32'h0);
    chk(resp, 2'h2);
    rc(12'h510, 32'h0);
    rc(12'h51C, 32'h0);
    rc(12'h520, 32'h0);
    $display("t_reset done");
endtask
task automatic t_config;
    wr(12'h510, 32'h000100FF);
    chk(resp, 2'h0);
    chk(transmit_swing_select, 1'b1);
    wr(12'h510, 32'h0000F0AA, 4'h1);
    rc(12'h510, 32'h000100AA);
    wr(12'h510, 32'h000100FF);
    repeat (6) @(posedge aclk);
    chk(receiver_detected, 8'hFF);
    merged_mode <= 1'b0;
    repeat (6) @(posedge aclk);
    chk(receiver_detected, 8'h0F);
    merged_mode <= 1'b1;
    port_is_odd <= 1'b1;
    repeat (6) @(posedge aclk);
    chk(receiver_detected, 8'h0F);
    port_is_odd <= 1'b0;
    present <= 8'h05;
    serdes_test_mode <= 1'b1;
    repeat (6) @(posedge aclk);
    chk(receiver_detected, 8'h05);
    present <= 8'h00;
    repeat (6) @(posedge aclk);
    chk(receiver_detected, 8'h00);
    serdes_test_mode <= 1'b0;
    wr(12'h510, 32'h0);
    chk(transmit_swing_select, 1'b0);
    $display("t_config done");
endtask
task automatic t_events;
    fire(4'hF, 8'hFF);
    chk(irq, 1'b0);
    chk(n_lrise, n_lclk);
    chk(n_lclk > 0, 1'b1);
    rc(12'h51C, 32'h00FF00FF);
    rc(12'h520, 32'h00FF00FF);
    wr(12'h534, 32'h0000000F);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b1);
    rc(12'h530, 32'h0000000F);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0);
    wr(12'h51C, 32'h00FF00FF);
    rc(12'h51C, 32'h0);
    wr(12'h520, 32'h000000F0);
    rc(12'h520, 32'h00FF000F);
    $display("t_events done");
endtask
task automatic t_gating;
    logic [3:0] st [4] = '{4'h2, 4'hA, 4'hB, 4'h0};
    wr(12'h520, 32'hFFFFFFFF);
    for (int i = 0; i < 4; i++)
    begin
        ltssm_state <= st[i];
        fire(4'hF, 8'h01 << i);
    end
    rc(12'h51C, 32'h00070000);
    rc(12'h520, 32'h0);
    ltssm_state <= 4'h3;
    port_is_odd <= 1'b1;
    fire(4'h1, 8'hF0);
    port_is_odd <= 1'b0;
    merged_mode <= 1'b0;
    fire(4'h2, 8'hF0);
    merged_mode <= 1'b1;
    rc(12'h51C, 32'h00070000);
    $display("t_gating done");
endtask
task automatic t_sticky;
    fire(4'hF, 8'h3C);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    rc(12'h51C, 32'h0);
    rc(12'h520, 32'h003C003C);
    fund_resetn <= 1'b0;
    repeat (3) @(posedge aclk);
    fund_resetn <= 1'b1;
    rc(12'h520, 32'h0);
    $display("t_sticky done");
endtask
initial
begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    fund_resetn <= 1'b1;
    repeat (3) @(posedge aclk);
    t_reset;
    t_config;
    t_events;
    t_gating;
    t_sticky;
    close_out;
end
initial
begin
    #200000;
    n_fail++;
    close_out;
end
endmodule // serdes_lane_status_config_tb
bind serdes_lane_status_config serdes_lane_status_config_checker chk_inst (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_araddr, .s_axi_rdata, .port_is_odd,
    .serdes_test_mode, .transmit_swing_select, .lane_clk_rise, .irq, .receiver_detected_raw, .receiver_detected);
